// >>> logic/iss_pkg.sv
package iss_pkg;

    // ****************************************
    // Register map
    // ****************************************
    // Printed state offset is not word aligned, so byte address is four times the index
    localparam logic [11:0] STATE_IDX = 12'h0d9;
    localparam logic [11:0] CTRL_IDX = 12'h0d8;
    localparam logic [11:0] ADDR_STATE = 12'h364;
    localparam logic [11:0] ADDR_CTRL = 12'h360;
    localparam logic [11:0] ADDR_SCLH = 12'h368;
    localparam logic [11:0] ADDR_SCLL = 12'h36c;
    localparam logic [11:0] ADDR_ISTAT = 12'h370;
    localparam logic [11:0] ADDR_IMASK = 12'h374;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_FLAG_BIT = 3;
    localparam int CTRL_EN_BIT = 6;
    localparam int CTRL_LINE_BIT = 8;
    localparam int STATE_LSB = 3;
    localparam int IRQ_STATE_BIT = 0;
    localparam int IRQ_BADCODE_BIT = 1;
    localparam logic [4:0] STATE_RESET = 5'h00;
    localparam logic [4:0] STATE_IDLE = 5'h1f;
    localparam logic [7:0] SCL_COUNT_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // Codes 08h..c8h plus f8h: 25 busy states and the idle one
    localparam logic [31:0] DEFINED_CODES = 32'h83ff_fffe;

    // ****************************************
    // Bus answers
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic valid;
        logic [4:0] code;
    } iss_state_evt_t;

    typedef struct packed {
        logic enable;
        logic src_sel;
        logic [7:0] high;
        logic [7:0] low;
    } iss_scl_cfg_t;

endpackage

// >>> logic/iss_scl_gen.sv
`timescale 1ns/1ps
module iss_scl_gen
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire iss_pkg::iss_scl_cfg_t cfg,
    input wire logic timer_ovf,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    output logic scl_line
);
    logic [8:0] cnt_r;
    logic high_r;
    logic sync1_r;
    logic sync2_r;
    logic [8:0] hi_ld;
    logic [8:0] lo_ld;

    // ****************************************
    // Phase lengths
    // ****************************************
    // One peripheral clock is two aclk cycles; a zero count acts as one
    assign hi_ld = {(cfg.high == 8'h00) ? 8'h01 : cfg.high, 1'b0} - 9'h001;
    assign lo_ld = {(cfg.low == 8'h00) ? 8'h01 : cfg.low, 1'b0} - 9'h001;

    // ****************************************
    // Clock generation
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            high_r <= 1'b1;
            cnt_r <= 9'h000;
        end
        else if (!cfg.enable)
        begin
            // Parked high with a full high phase loaded, so the first phase is whole
            high_r <= 1'b1;
            cnt_r <= hi_ld;
        end
        else if (cfg.src_sel)
        begin
            cnt_r <= 9'h000;
            if (timer_ovf)
                high_r <= !high_r;
        end
        else if (cnt_r == 9'h000)
        begin
            // Fresh phase picks up the count written most recently
            high_r <= !high_r;
            cnt_r <= high_r ? lo_ld : hi_ld;
        end
        else
            cnt_r <= cnt_r - 9'h001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            scl_oe_n <= 1'b1;
            scl_o <= 1'b0;
        end
        else
        begin
            scl_oe_n <= high_r;
            scl_o <= 1'b0;
        end
    end

    // Pin level reaches software only through all three flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            scl_line <= 1'b1;
        end
        else
        begin
            sync1_r <= scl_i;
            sync2_r <= sync1_r;
            scl_line <= sync2_r;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic [8:0] len_r;
    logic [8:0] exp_r;
    logic [8:0] hi_prev_r;
    logic [8:0] lo_prev_r;

    // Lengths as they stood when the phase was loaded, so a late count write is no false alarm
    always_ff @(posedge aclk)
    begin
        hi_prev_r <= hi_ld;
        lo_prev_r <= lo_ld;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !cfg.enable || cfg.src_sel)
        begin
            len_r <= 9'h000;
            exp_r <= hi_ld + 9'h001;
        end
        else if (high_r != $past(high_r))
        begin
            len_r <= 9'h001;
            exp_r <= (high_r ? hi_prev_r : lo_prev_r) + 9'h001;
        end
        else
            len_r <= len_r + 9'h001;
    end

    a_high_time: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(high_r) && cfg.enable && !cfg.src_sel && $stable(cfg)
        && !$past(cfg.src_sel, 2) |-> len_r == exp_r)
        else $error("scl high time wrong");
    a_low_time: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(high_r) && $past(cfg.enable) && !cfg.src_sel && $stable(cfg)
        && !$past(cfg.src_sel, 2) |-> len_r == exp_r)
        else $error("scl low time wrong");
    a_timer_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg.enable && cfg.src_sel && timer_ovf |=> high_r != $past(high_r))
        else $error("timer overflow did not toggle scl");

endmodule // iss_scl_gen

// >>> logic/iss_top.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module iss_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire iss_pkg::iss_state_evt_t state_evt,
    input wire logic timer_ovf,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    output logic serial_flag,
    output logic irq
);
    logic [11:0] awaddr_r;
    logic aw_got_r;
    logic [7:0] wdata_r;
    logic wbyte_r;
    logic w_got_r;
    logic wr_go;
    logic wr_hit;
    logic [4:0] state_code_r;
    logic flag_r;
    logic src_r;
    logic en_r;
    logic [7:0] sclh_r;
    logic [7:0] scll_r;
    logic [1:0] istat_r;
    logic [1:0] imask_r;
    logic [1:0] ev_nxt;
    logic code_ok;
    logic line_lvl;
    logic [31:0] rd_nxt;
    logic rd_hit;
    iss_pkg::iss_scl_cfg_t cfg;

    // ****************************************
    // Write channel
    // ****************************************
    // Address and data are taken in either order; the answer waits for both
    assign wr_go = aw_got_r && w_got_r && !s_bvalid;
    assign wr_hit = (awaddr_r == iss_pkg::ADDR_STATE) || (awaddr_r == iss_pkg::ADDR_CTRL)
        || (awaddr_r == iss_pkg::ADDR_SCLH) || (awaddr_r == iss_pkg::ADDR_SCLL)
        || (awaddr_r == iss_pkg::ADDR_ISTAT) || (awaddr_r == iss_pkg::ADDR_IMASK);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            awaddr_r <= 12'h000;
            wdata_r <= 8'h00;
            wbyte_r <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= iss_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_awvalid && s_awready)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= {s_awaddr[11:2], 2'b00};
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_wdata[7:0];
                wbyte_r <= s_wstrb[0];
                s_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_hit ? iss_pkg::RESP_OKAY : iss_pkg::RESP_SLVERR;
            end
            if (s_bvalid && s_bready)
            begin
                s_bvalid <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
        end
    end

    // ****************************************
    // State code and serial flag
    // ****************************************
    assign code_ok = iss_pkg::DEFINED_CODES[state_evt.code];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_code_r <= iss_pkg::STATE_RESET;
        else if (state_evt.valid && code_ok)
            state_code_r <= state_evt.code;
    end

    // A new busy state wins over a clearing write in the same cycle; the idle code does not
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flag_r <= 1'b0;
        else if (state_evt.valid && code_ok && state_evt.code != iss_pkg::STATE_IDLE)
            flag_r <= 1'b1;
        else if (wr_go && wbyte_r && awaddr_r == iss_pkg::ADDR_CTRL
                && !wdata_r[iss_pkg::CTRL_FLAG_BIT])
            flag_r <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            serial_flag <= 1'b0;
        else
            serial_flag <= flag_r;
    end

    // ****************************************
    // Control and count registers
    // ****************************************
    // Counts below four are accepted; keeping them legal is up to software
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_r <= 1'b0;
            en_r <= 1'b0;
            sclh_r <= iss_pkg::SCL_COUNT_RESET;
            scll_r <= iss_pkg::SCL_COUNT_RESET;
            imask_r <= iss_pkg::IRQ_RESET;
        end
        else if (wr_go && wbyte_r)
        begin
            if (awaddr_r == iss_pkg::ADDR_CTRL)
            begin
                src_r <= wdata_r[iss_pkg::CTRL_SRC_BIT];
                en_r <= wdata_r[iss_pkg::CTRL_EN_BIT];
            end
            if (awaddr_r == iss_pkg::ADDR_SCLH)
                sclh_r <= wdata_r;
            if (awaddr_r == iss_pkg::ADDR_SCLL)
                scll_r <= wdata_r;
            if (awaddr_r == iss_pkg::ADDR_IMASK)
                imask_r <= wdata_r[1:0];
        end
    end

    // ****************************************
    // Interrupt status
    // ****************************************
    always_comb
    begin
        ev_nxt = 2'h0;
        ev_nxt[iss_pkg::IRQ_STATE_BIT] = state_evt.valid && code_ok
            && state_evt.code != iss_pkg::STATE_IDLE;
        ev_nxt[iss_pkg::IRQ_BADCODE_BIT] = state_evt.valid && !code_ok;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            istat_r <= iss_pkg::IRQ_RESET;
        else if (wr_go && wbyte_r && awaddr_r == iss_pkg::ADDR_ISTAT)
            istat_r <= (istat_r & ~wdata_r[1:0]) | ev_nxt;
        else
            istat_r <= istat_r | ev_nxt;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq <= 1'b0;
        else
            irq <= |(istat_r & imask_r);
    end

    // ****************************************
    // Read channel
    // ****************************************
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_araddr[11:2])
            iss_pkg::ADDR_STATE[11:2]:
                rd_nxt[7:0] = {state_code_r, 3'b000};
            iss_pkg::ADDR_CTRL[11:2]:
            begin
                rd_nxt[iss_pkg::CTRL_SRC_BIT] = src_r;
                rd_nxt[iss_pkg::CTRL_FLAG_BIT] = flag_r;
                rd_nxt[iss_pkg::CTRL_EN_BIT] = en_r;
                rd_nxt[iss_pkg::CTRL_LINE_BIT] = line_lvl;
            end
            iss_pkg::ADDR_SCLH[11:2]:
                rd_nxt[7:0] = sclh_r;
            iss_pkg::ADDR_SCLL[11:2]:
                rd_nxt[7:0] = scll_r;
            iss_pkg::ADDR_ISTAT[11:2]:
                rd_nxt[1:0] = istat_r;
            iss_pkg::ADDR_IMASK[11:2]:
                rd_nxt[1:0] = imask_r;
            default:
                rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= iss_pkg::RESP_OKAY;
        end
        else if (s_arvalid && s_arready)
        begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata <= rd_nxt;
            s_rresp <= rd_hit ? iss_pkg::RESP_OKAY : iss_pkg::RESP_SLVERR;
        end
        else if (s_rvalid && s_rready)
        begin
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
        end
    end

    // ****************************************
    // Serial clock
    // ****************************************
    assign cfg = '{enable: en_r, src_sel: src_r, high: sclh_r, low: scll_r};

    iss_scl_gen u_scl
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg),
        .timer_ovf(timer_ovf),
        .scl_i(scl_i),
        .scl_o(scl_o),
        .scl_oe_n(scl_oe_n),
        .scl_line(line_lvl)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic rd_state_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rd_state_r <= 1'b0;
        else if (s_arvalid && s_arready)
            rd_state_r <= s_araddr[11:2] == iss_pkg::ADDR_STATE[11:2];
    end

    a_state_low_zero: assert property (
        s_rvalid && rd_state_r |-> s_rdata[2:0] == 3'b000 && s_rdata[31:8] == 24'h0)
        else $error("state read has nonzero low bits");
    a_state_code_kept: assert property (
        state_evt.valid && code_ok |=> state_code_r == $past(state_evt.code))
        else $error("state code not stored");
    a_idle_no_flag: assert property (
        state_evt.valid && state_evt.code == iss_pkg::STATE_IDLE && !flag_r |=> !flag_r)
        else $error("idle code raised the flag");
    a_busy_sets_flag: assert property (
        ev_nxt[iss_pkg::IRQ_STATE_BIT] |=> flag_r ##1 serial_flag)
        else $error("busy state did not raise flag");
    a_flag_clear: assert property (
        wr_go && wbyte_r && awaddr_r == iss_pkg::ADDR_CTRL && !wdata_r[3]
        && !ev_nxt[iss_pkg::IRQ_STATE_BIT] |=> !flag_r)
        else $error("flag not cleared by zero write");
    a_src_follows: assert property (
        wr_go && wbyte_r && awaddr_r == iss_pkg::ADDR_CTRL |=> src_r == $past(wdata_r[0]))
        else $error("clock source select not taken");
    a_write_answer: assert property (
        wr_go |=> s_bvalid && !aw_got_r && !w_got_r)
        else $error("write answer missing");
    a_irq_level: assert property (
        (|(istat_r & imask_r)) [*2] |-> irq)
        else $error("irq low with unmasked status");

    c_busy_state: cover property (ev_nxt[iss_pkg::IRQ_STATE_BIT] ##[1:50] !flag_r);
    c_timer_mode: cover property (src_r && en_r && timer_ovf);
    c_read_state: cover property (s_rvalid && rd_state_r && s_rdata[7:3] != 5'h00);

endmodule // iss_top

// >>> testbench/iss_bus_peer.sv
`timescale 1ns/1ps
// ****************************************
// Far-side bus party with line pull-up
// ****************************************
module iss_bus_peer
(
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic hold_low,
    output logic scl_line
);
    // Released line goes to the pull-up level, never keeps an old value
    assign scl_line = ((!scl_oe_n && !scl_o) || hold_low) ? 1'b0 : 1'b1;
endmodule // iss_bus_peer

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0;
    logic [31:0] s_wdata = 32'h0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, r;
    logic [31:0] s_rdata, d;
    iss_pkg::iss_state_evt_t state_evt = '0;
    logic timer_ovf = 1'b0, hold_low = 1'b0;
    logic scl_o, scl_oe_n, scl_line, serial_flag, irq, v;
    int num_errors = 0, samples_checked = 0, lo, hi;

    always #50 aclk = ~aclk;

    iss_top dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .state_evt(state_evt), .timer_ovf(timer_ovf), .scl_i(scl_line), .scl_o(scl_o),
        .scl_oe_n(scl_oe_n), .serial_flag(serial_flag), .irq(irq));

    iss_bus_peer peer (.scl_o(scl_o), .scl_oe_n(scl_oe_n), .hold_low(hold_low),
        .scl_line(scl_line));

    // ****************************************
    // Compare and closing
    // ****************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // Register bus master
    // ****************************************
    task automatic axw(input logic [11:0] a, input logic [31:0] dat);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_awaddr <= a;
        s_wdata <= dat;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (s_awvalid && s_awready)
            begin
                aw = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (s_wvalid && s_wready)
            begin
                w = 1'b1;
                s_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_bvalid !== 1'b1);
        r = s_bresp;
        s_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axr(input logic [11:0] a);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge aclk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (s_rvalid !== 1'b1);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic evt(input logic [4:0] c);
        state_evt <= {1'b1, c};
        @(posedge aclk);
        state_evt <= '0;
        repeat (2) @(posedge aclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_map;
        axr(iss_pkg::ADDR_STATE);
        chk_word(d, 32'h0);
        axw(iss_pkg::ADDR_STATE, 32'hff);
        chk_word({30'h0, r}, {30'h0, iss_pkg::RESP_OKAY});
        axr(iss_pkg::ADDR_STATE);
        chk_word(d, 32'h0);
        axr(12'h3fc);
        chk_word({d[31:2], r}, {30'h0, iss_pkg::RESP_SLVERR});
        axw(12'h3fc, 32'h0);
        chk_word({30'h0, r}, {30'h0, iss_pkg::RESP_SLVERR});
        hold_low <= 1'b1;
        repeat (4) @(posedge aclk);
        axr(iss_pkg::ADDR_CTRL);
        chk_bit(d[iss_pkg::CTRL_LINE_BIT], 1'b0);
        hold_low <= 1'b0;
    endtask

    task automatic t_all_states;
        for (int c = 1; c <= 25; c++)
        begin
            evt(5'(c));
            chk_bit(serial_flag, 1'b1);
            axr(iss_pkg::ADDR_STATE);
            chk_word(d, 32'(c) << iss_pkg::STATE_LSB);
            // Flag must be dropped by software before the next state
            axw(iss_pkg::ADDR_CTRL, 32'h0);
            chk_bit(serial_flag, 1'b0);
        end
        evt(iss_pkg::STATE_IDLE);
        chk_bit(serial_flag, 1'b0);
        axr(iss_pkg::ADDR_STATE);
        chk_word(d, 32'hf8);
        evt(5'h1a);
        axr(iss_pkg::ADDR_STATE);
        chk_word(d, 32'hf8);
        axr(iss_pkg::ADDR_ISTAT);
        chk_word(d, 32'h3);
        axw(iss_pkg::ADDR_ISTAT, 32'h3);
    endtask

    task automatic t_irq;
        axw(iss_pkg::ADDR_IMASK, 32'h1);
        evt(5'h02);
        chk_bit(irq, 1'b1);
        axw(iss_pkg::ADDR_ISTAT, 32'h1);
        chk_bit(irq, 1'b0);
        axw(iss_pkg::ADDR_CTRL, 32'h0);
        axw(iss_pkg::ADDR_IMASK, 32'h0);
        evt(5'h03);
        chk_bit(irq, 1'b0);
        axr(iss_pkg::ADDR_ISTAT);
        chk_word(d, 32'h1);
        axw(iss_pkg::ADDR_ISTAT, 32'h1);
        axw(iss_pkg::ADDR_CTRL, 32'h0);
    endtask

    task automatic phase(input logic lvl, output int n);
        n = 0;
        while (scl_line !== lvl) @(posedge aclk);
        while (scl_line === lvl)
        begin
            n++;
            @(posedge aclk);
        end
    endtask

    task automatic t_internal_rate;
        // Both counts above three keep the rate legal
        axw(iss_pkg::ADDR_SCLH, 32'h4);
        axw(iss_pkg::ADDR_SCLL, 32'h6);
        axw(iss_pkg::ADDR_CTRL, 32'h40);
        phase(1'b1, hi);
        phase(1'b0, lo);
        phase(1'b1, hi);
        chk_word(32'(lo), 32'd12);
        chk_word(32'(hi), 32'd8);
        chk_word(32'(lo + hi), 32'd20);
        chk_bit(lo != hi, 1'b1);
        chk_bit(scl_o, 1'b0);
    endtask

    task automatic t_timer_source;
        axw(iss_pkg::ADDR_CTRL, 32'h41);
        repeat (2)
        begin
            repeat (3) @(posedge aclk);
            v = scl_line;
            timer_ovf <= 1'b1;
            @(posedge aclk);
            timer_ovf <= 1'b0;
            repeat (3) @(posedge aclk);
            chk_bit(scl_line, ~v);
        end
        axw(iss_pkg::ADDR_CTRL, 32'h0);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_map();
        t_all_states();
        t_irq();
        t_internal_rate();
        t_timer_source();
        tally_and_finish();
    end

    initial
    begin
        // Whole run needs well under a thousand cycles, so 30000 cycles leaves a wide margin
        #(30000 * 100);
        num_errors++;
        tally_and_finish();
    end
endmodule // tb_top
